// ---- pkg/bac_map.svh ----
`ifndef BAC_MAP_SVH
`define BAC_MAP_SVH
`define BAC_CTRL_RESET      8'h00
`define BAC_VSEL_MSB        7
`define BAC_VSEL_LSB        5
`define BAC_SHORT_EN_BIT    4
`define BAC_STANDBY_BIT     3
`define BAC_CONV_EN_BIT     2
`define BAC_AMP_AMP_SHUTDOWN_BIT    1
`define BAC_UNUSED_BIT      0
`define BAC_STATUS_SHORT_BIT 2
`define BAC_FRAC_MIN_PCT    8'h1E
`define BAC_FRAC_STEP_PCT   8'h0A
`define BAC_VPP_MIN_DV      12'h2A3
`define BAC_VPP_STEP_DV     12'hE1
`endif

// ---- pkg/bac_pkg.sv ----
package bac_pkg;
  typedef struct packed {
    logic [2:0] vsel;
    logic       short_protect_enable;
    logic       output_standby;
    logic       conv_enable;
    logic       amp_shutdown;
  } bac_ctrl_s;

  typedef struct packed {
    logic       converter_run;
    logic       amp_enable;
    logic [7:0] ref_fraction_pct;
    logic [11:0] vpp_target_dv;
  } bac_drive_s;

  typedef enum logic [1:0] {
    BAC_OFF   = 2'b00,
    BAC_RUN   = 2'b01,
    BAC_FAULT = 2'b11
  } bac_state_e;
endpackage

// ---- src/bac_vsel_decode.sv ----
`timescale 1ns/1ps
`include "bac_map.svh"
module bac_vsel_decode (
  input  wire logic [2:0]  i_code,
  output logic      [7:0]  o_fraction_pct,
  output logic      [11:0] o_vpp_dv
);
  // Ascending map: code 0 is the lowest level, code 7 full scale
  always_comb begin
    o_fraction_pct = `BAC_FRAC_MIN_PCT + 8'(i_code) * `BAC_FRAC_STEP_PCT;
    o_vpp_dv       = `BAC_VPP_MIN_DV + 12'(i_code) * `BAC_VPP_STEP_DV;
  end
endmodule

// ---- src/bac_control.sv ----
`timescale 1ns/1ps
`include "bac_map.svh"
// Overview of operation
// - Control bits 7-5 hold the voltage-select code for the converter target.
// - Code picks fractions 0.30 to 1.00, targets 67.5 V to 225 V.
// - Short detection active only when enabled and the converter operates.
// - Detected short sets status bit 2 and suspends the converter.
// - With protection disabled, shorts are ignored; a flag already set is held.
// - Standby bit 3 disables converter output, rest keeps running.
// - Bit 2 enables the step-up converter.
// - Bit 1 shuts down both amplifiers.
// - Short flag clears on a falling edge of converter enable.
module bac_control (
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  input  wire logic               i_ctrl_write,
  input  wire logic [7:0]         i_ctrl_wdata,
  input  wire logic               i_current_sense_pos,
  input  wire logic               i_current_sense_neg,
  output logic      [7:0]         o_converter_amp_control,
  output logic      [7:0]         o_fault_status,
  output bac_pkg::bac_drive_s     o_drive,
  output logic                    o_output_standby,
  output bac_pkg::bac_state_e     o_state
);
  import bac_pkg::*;

  typedef struct packed {
    bac_ctrl_s  ctrl;
    logic       short_flag;
    bac_state_e state;
    bac_drive_s drive;
  } bac_regs_s;

  bac_regs_s   regs;
  bac_regs_s   next_regs;
  bac_ctrl_s   next_ctrl;
  logic [7:0]  dec_frac;
  logic [11:0] dec_vpp;
  logic        short_event;

  bac_vsel_decode u_decode (
    .i_code         (next_ctrl.vsel),
    .o_fraction_pct (dec_frac),
    .o_vpp_dv       (dec_vpp)
  );

  // Sense pair differential high current means a short
  assign short_event = i_current_sense_pos & ~i_current_sense_neg;

  always_comb begin
    next_regs = regs;
    next_ctrl = regs.ctrl;
    if (i_ctrl_write) begin
      next_ctrl.vsel                 = i_ctrl_wdata[`BAC_VSEL_MSB:`BAC_VSEL_LSB];
      next_ctrl.short_protect_enable = i_ctrl_wdata[`BAC_SHORT_EN_BIT];
      next_ctrl.output_standby       = i_ctrl_wdata[`BAC_STANDBY_BIT];
      next_ctrl.conv_enable          = i_ctrl_wdata[`BAC_CONV_EN_BIT];
      next_ctrl.amp_shutdown         = i_ctrl_wdata[`BAC_AMP_AMP_SHUTDOWN_BIT];
      // Bit 0 has no storage at all
    end
    next_regs.ctrl = next_ctrl;

    // Falling edge of enable clears and outranks a short seen in the
    // same cycle, so a disabled converter never comes back flagged.
    if (regs.ctrl.conv_enable && !next_ctrl.conv_enable) begin
      next_regs.short_flag = 1'b0;
    end else if (regs.ctrl.short_protect_enable && regs.state == BAC_RUN
                 && short_event) begin
      next_regs.short_flag = 1'b1;
    end
    if (!next_ctrl.short_protect_enable && !regs.short_flag) begin
      next_regs.short_flag = 1'b0;
    end

    case (regs.state)
      BAC_OFF: begin
        if (next_ctrl.conv_enable) begin
          next_regs.state = BAC_RUN;
        end
      end
      BAC_RUN: begin
        if (!next_ctrl.conv_enable) begin
          next_regs.state = BAC_OFF;
        end else if (next_regs.short_flag) begin
          next_regs.state = BAC_FAULT;
        end
      end
      BAC_FAULT: begin
        // Held suspended until enable drops
        if (!next_ctrl.conv_enable) begin
          next_regs.state = BAC_OFF;
        end
      end
      default: begin
        next_regs.state = BAC_OFF;
      end
    endcase

    next_regs.drive.converter_run    = (next_regs.state == BAC_RUN)
                                       && !next_ctrl.output_standby;
    next_regs.drive.amp_enable       = !next_ctrl.amp_shutdown;
    next_regs.drive.ref_fraction_pct = dec_frac;
    next_regs.drive.vpp_target_dv    = dec_vpp;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      regs <= '{ctrl: bac_ctrl_s'(7'h00), short_flag: 1'b0, state: BAC_OFF,
                 drive: '{converter_run: 1'b0, amp_enable: 1'b1,
                          ref_fraction_pct: `BAC_FRAC_MIN_PCT,
                          vpp_target_dv: `BAC_VPP_MIN_DV}};
    end else begin
      regs <= next_regs;
    end
  end

  assign o_converter_amp_control = {regs.ctrl, 1'b0};
  assign o_fault_status   = {5'h00, regs.short_flag, 2'h0};
  assign o_drive          = regs.drive;
  assign o_output_standby = regs.ctrl.output_standby;
  assign o_state          = regs.state;
endmodule

// ---- testbench/bac_chk.sv ----
`timescale 1ns/1ps
module bac_chk (
  input logic       i_clock,
  input logic       i_reset_n,
  input logic       i_ctrl_write,
  input logic [7:0] i_ctrl_wdata,
  input logic       i_current_sense_pos,
  input logic       i_current_sense_neg,
  input logic [7:0] o_converter_amp_control,
  input logic [7:0] o_fault_status,
  input logic       o_output_standby
);
  wire [7:0] c = o_converter_amp_control;
  wire [7:0] f = o_fault_status;
  wire       w = i_ctrl_write;
  wire       h = i_current_sense_pos && !i_current_sense_neg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_hit; c[4] && c[2] && !f[2] && h && !w; endsequence
  property p_set; s_hit |=> f == 8'h04; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_wr; w |=> c == {$past(i_ctrl_wdata[7:1]), 1'b0}; endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_stb; o_output_standby == c[3]; endproperty
  a_stb: assert property (p_stb) else $error("stb");
  property p_ign; $rose(f[2]) |-> $past(c[4]); endproperty
  a_ign: assert property (p_ign) else $error("ign");
  property p_clr; c[2] && w && !i_ctrl_wdata[2] |=> !f[2]; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_hold; f[2] && !(w && !i_ctrl_wdata[2]) |=> f[2]; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_off; !c[4] && !f[2] && !w |=> !f[2]; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_bits; (f & 8'hFB) == 8'h00; endproperty
  a_bits: assert property (p_bits) else $error("bits");
endmodule
bind bac_control bac_chk u_chk (.*);

// ---- testbench/bac_host.sv ----
`timescale 1ns/1ps
module bac_host (
  input  wire logic  i_clock,
  output logic       o_write = 1'b0,
  output logic [7:0] o_wdata = 8'h00
);
  task automatic wr(input logic [7:0] d);
    @(posedge i_clock);
    #1 o_write = 1'b1;
    o_wdata = d;
    @(posedge i_clock);
    #1 o_write = 1'b0;
    o_wdata = ~d; // Stale byte must not pass as valid
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_ctrl_write, o_output_standby;
  logic i_current_sense_pos = 1'b0, i_current_sense_neg = 1'b1;
  logic [7:0] i_ctrl_wdata, o_converter_amp_control, o_fault_status;
  bac_pkg::bac_drive_s o_drive;
  bac_pkg::bac_state_e o_state;
  int n_fail = 0, num_checks = 0, m_c = 0, m_f = 0;
  logic [31:0] r = 32'h7F0B;
  always #25 i_clock = ~i_clock;
  bac_host u_host (.i_clock(i_clock), .o_write(i_ctrl_write), .o_wdata(i_ctrl_wdata));
  bac_control dut (.*);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    n_fail += (g !== e);
    if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
  endtask
  task rst_chk;
    chk(o_converter_amp_control, 8'h00);
    chk(o_fault_status, 8'h00);
    chk(o_state, bac_pkg::BAC_OFF);
    chk(o_drive, {1'b0, 1'b1, 8'h1E, 12'h2A3});
  endtask
  task wrap_up;
    $display("%0d checks, %0d fails", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task w(input logic [7:0] d, input logic p);
    m_f = m_f && !(m_c[2] && !d[2]);
    m_c = d;
    u_host.wr(d);
    i_current_sense_pos = p;
    i_current_sense_neg = !p;
    @(posedge i_clock);
    m_f = m_f || (p && d[4] && d[2]);
    #1 i_current_sense_pos = 1'b0;
    i_current_sense_neg = 1'b1;
    chk(o_converter_amp_control, d & 8'hFE);
    chk(o_fault_status, 4 * m_f);
    chk(o_output_standby, d[3]);
    chk(o_drive, {d[2] && !d[3] && !m_f, !d[1],
      8'h1E + 8'h0A * d[7:5], 12'h2A3 + 12'hE1 * d[7:5]});
    chk(o_state, !d[2] ? bac_pkg::BAC_OFF
      : (m_f ? bac_pkg::BAC_FAULT : bac_pkg::BAC_RUN));
  endtask
  initial begin
    repeat (2000) @(posedge i_clock);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    rst_chk;
    w(8'h04, 1'b1); // Protection held off while starting
    for (int i = 0; i < 8; i++) w({i[2:0], 5'h15}, i[0]);
    w(8'hF4, 1'b1);
    w(8'hF0, 1'b0);
    repeat (60) begin
      r = nx(r);
      w(r[7:0], r[8]);
    end
    // Reset in mid-run must drop a pending flag and all control bits
    #1 i_reset_n = 1'b0;
    @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    m_c = 0;
    m_f = 0;
    rst_chk;
    w(8'h34, 1'b1);
    wrap_up;
  end
endmodule
